/* scg_cfg.svh */
// Constants of the sleep clock gate control block: offsets, field positions, reset values.
// Assumes inclusion by bare name from the design modules and the bench.
`ifndef SCG_CFG_SVH
`define SCG_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SCG_ADDR_W      12
`define SCG_OFF_RUN     12'h104
`define SCG_OFF_SLEEP   12'h114
`define SCG_OFF_CTRL    12'h180
`define SCG_OFF_STAT    12'h184
`define SCG_OFF_MASK    12'h188
`define SCG_OFF_FLT     12'h18c

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SCG_BIT_CMP2    26
`define SCG_BIT_CMP1    25
`define SCG_BIT_CMP0    24
`define SCG_BIT_CNT2    18
`define SCG_BIT_CNT1    17
`define SCG_BIT_CNT0    16
`define SCG_BIT_TWI0    12
`define SCG_BIT_SSP0    4
`define SCG_BIT_ASP0    0
`define SCG_BIT_AUTO    0
`define SCG_EV_FAULT    0
`define SCG_EV_SWITCH   1
`define SCG_GATE_RST    32'h0000_0000
`define SCG_EV_RST      2'h0
`define SCG_RESP_OKAY   2'h0
`define SCG_RESP_SLVERR 2'h2

`endif

/* scg_pkg.sv */
// Types of the sleep clock gate control block.
// Assumes scg_cfg.svh alongside; holds types only.
package scg_pkg;

	// ----------------------------------------------------------------
	// Gate register layout
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0] rsv_hi;
		logic       comparator2_gate;
		logic       comparator1_gate;
		logic       comparator0_gate;
		logic [4:0] rsv_mid;
		logic       gp_counter2_gate;
		logic       gp_counter1_gate;
		logic       gp_counter0_gate;
		logic [2:0] rsv_b13;
		logic       twowire_port0_gate;
		logic [6:0] rsv_lo;
		logic       sync_serial_port0_gate;
		logic [2:0] rsv_b1;
		logic       async_serial_port0_gate;
	} scg_gate_t;

	// Peripheral access seen on the system bus
	typedef struct packed {
		logic        valid;
		logic [31:0] unit_sel;
	} scg_preq_t;

	// Which gate register drives the enables
	typedef enum logic {
		SCG_SRC_RUN,
		SCG_SRC_SLEEP
	} scg_src_t;

endpackage

/* scg_gate_mux.sv */
// Per-unit clock enable selection between run and sleep gate settings.
// Assumes run and sleep settings and the mode select come from the same clock domain.
`timescale 1ns/1ps
`include "scg_cfg.svh"

module scg_gate_mux (
	input  wire logic             ref_clk_in,
	input  wire logic             sys_rst_in,
	input  wire scg_pkg::scg_gate_t run_gate_in,
	input  wire scg_pkg::scg_gate_t sleep_gate_in,
	input  wire scg_pkg::scg_src_t  src_in,
	output scg_pkg::scg_gate_t      clk_en_out,
	output logic                    switch_ev_out
);

	scg_pkg::scg_src_t src_r;

	// ----------------------------------------------------------------
	// Registered enables, so a source change never glitches a unit clock
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			clk_en_out <= scg_pkg::scg_gate_t'(`SCG_GATE_RST);
		end else if (src_in == scg_pkg::SCG_SRC_SLEEP) begin
			clk_en_out <= sleep_gate_in;
		end else begin
			clk_en_out <= run_gate_in;
		end
	end

	// Source tracking and one-cycle pulse on each switch
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			src_r         <= scg_pkg::SCG_SRC_RUN;
			switch_ev_out <= 1'b0;
		end else begin
			src_r         <= src_in;
			switch_ev_out <= (src_in != src_r);
		end
	end

endmodule // scg_gate_mux

/* scg_fault_chk.sv */
// Bus fault check for accesses to peripheral units.
// Assumes the request is on the same clock and names its units by gate bit.
`timescale 1ns/1ps
`include "scg_cfg.svh"

module scg_fault_chk (
	input  wire logic               ref_clk_in,
	input  wire logic               sys_rst_in,
	input  wire scg_pkg::scg_preq_t preq_in,
	input  wire scg_pkg::scg_gate_t clk_en_in,
	output logic                    fault_out,
	output logic [31:0]             fault_units_out
);

	logic [31:0] gated_hit;

	// Units addressed while their clock is off
	assign gated_hit = preq_in.unit_sel & ~clk_en_in;

	// ----------------------------------------------------------------
	// One-cycle fault pulse and the offending units
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			fault_out       <= 1'b0;
			fault_units_out <= 32'h0000_0000;
		end else begin
			fault_out       <= preq_in.valid && (gated_hit != 32'h0000_0000);
			fault_units_out <= preq_in.valid ? gated_hit : 32'h0000_0000;
		end
	end

endmodule // scg_fault_chk

/* scg_top.sv */
// Sleep clock gate control: AXI4-Lite registers, enable selection, fault and interrupt.
// Assumes one clock; sleep status and peripheral requests come from logic on that clock.
`timescale 1ns/1ps
`include "scg_cfg.svh"

module scg_top (
	input  wire logic                      ref_clk_in,
	input  wire logic                      sys_rst_in,
	input  wire logic                      s_axi_awvalid_in,
	output logic                           s_axi_awready_out,
	input  wire logic [`SCG_ADDR_W-1:0]    s_axi_awaddr_in,
	input  wire logic                      s_axi_wvalid_in,
	output logic                           s_axi_wready_out,
	input  wire logic [31:0]               s_axi_wdata_in,
	input  wire logic [3:0]                s_axi_wstrb_in,
	output logic                           s_axi_bvalid_out,
	input  wire logic                      s_axi_bready_in,
	output logic [1:0]                     s_axi_bresp_out,
	input  wire logic                      s_axi_arvalid_in,
	output logic                           s_axi_arready_out,
	input  wire logic [`SCG_ADDR_W-1:0]    s_axi_araddr_in,
	output logic                           s_axi_rvalid_out,
	input  wire logic                      s_axi_rready_in,
	output logic [31:0]                    s_axi_rdata_out,
	output logic [1:0]                     s_axi_rresp_out,
	input  wire logic                      cpu_sleep_in,
	input  wire scg_pkg::scg_preq_t        preq_in,
	output scg_pkg::scg_gate_t             periph_clk_en_out,
	output logic                           bus_fault_out,
	output logic                           irq_out
);

	// ----------------------------------------------------------------
	// Writable bit mask of the gate registers
	// ----------------------------------------------------------------
	logic [31:0] gate_wmask;
	always_comb begin
		gate_wmask                  = 32'h0000_0000;
		gate_wmask[`SCG_BIT_CMP2]   = 1'b1;
		gate_wmask[`SCG_BIT_CMP1]   = 1'b1;
		gate_wmask[`SCG_BIT_CMP0]   = 1'b1;
		gate_wmask[`SCG_BIT_CNT2]   = 1'b1;
		gate_wmask[`SCG_BIT_CNT1]   = 1'b1;
		gate_wmask[`SCG_BIT_CNT0]   = 1'b1;
		gate_wmask[`SCG_BIT_TWI0]   = 1'b1;
		gate_wmask[`SCG_BIT_SSP0]   = 1'b1;
		gate_wmask[`SCG_BIT_ASP0]   = 1'b1;
	end

	// Byte-lane merge of write data into an old value
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	scg_pkg::scg_gate_t               run_gate_r;
	scg_pkg::scg_gate_t               sleep_gate_r;
	logic                             auto_gate_select_r;
	logic [1:0]                       stat_r;
	logic [1:0]                       stat_nxt;
	logic [1:0]                       mask_r;
	logic [31:0]                      fault_units_r;
	logic                             aw_held_r;
	logic                             w_held_r;
	logic [`SCG_ADDR_W-1:0]           waddr_r;
	logic [31:0]                      wdata_r;
	logic [3:0]                       wstrb_r;
	logic                             wr_fire;
	logic [31:0]                      rd_val;
	logic [1:0]                       rd_resp;
	scg_pkg::scg_src_t                src_sel;
	logic                             switch_ev;
	logic [31:0]                      fault_units;

	assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid_out;

	// Sleep bits rule only in Sleep with auto gating selected
	assign src_sel = (cpu_sleep_in && auto_gate_select_r) ? scg_pkg::SCG_SRC_SLEEP
		: scg_pkg::SCG_SRC_RUN;

	// ----------------------------------------------------------------
	// Write address and data capture, either order
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			waddr_r   <= '0;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_held_r <= 1'b1;
				waddr_r   <= s_axi_awaddr_in;
			end else if (wr_fire) begin
				aw_held_r <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_held_r <= 1'b1;
				wdata_r  <= s_axi_wdata_in;
				wstrb_r  <= s_axi_wstrb_in;
			end else if (wr_fire) begin
				w_held_r <= 1'b0;
			end
		end
	end

	// Ready while the channel holds nothing and no response waits
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out  <= 1'b0;
		end else begin
			s_axi_awready_out <= !(aw_held_r || (s_axi_awvalid_in && s_axi_awready_out))
				&& !wr_fire && !s_axi_bvalid_out;
			s_axi_wready_out  <= !(w_held_r || (s_axi_wvalid_in && s_axi_wready_out))
				&& !wr_fire && !s_axi_bvalid_out;
		end
	end

	// ----------------------------------------------------------------
	// Register writes and write response
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			run_gate_r         <= scg_pkg::scg_gate_t'(`SCG_GATE_RST);
			sleep_gate_r       <= scg_pkg::scg_gate_t'(`SCG_GATE_RST);
			auto_gate_select_r <= 1'b0;
			mask_r             <= `SCG_EV_RST;
			s_axi_bvalid_out   <= 1'b0;
			s_axi_bresp_out    <= `SCG_RESP_OKAY;
		end else begin
			if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= `SCG_RESP_OKAY;
				if (waddr_r == `SCG_OFF_SLEEP) begin
					sleep_gate_r <= lane_merge(sleep_gate_r, wdata_r, wstrb_r) & gate_wmask;
				end else if (waddr_r == `SCG_OFF_RUN) begin
					run_gate_r <= lane_merge(run_gate_r, wdata_r, wstrb_r) & gate_wmask;
				end else if (waddr_r == `SCG_OFF_CTRL) begin
					auto_gate_select_r <= wstrb_r[0] ? wdata_r[`SCG_BIT_AUTO] : auto_gate_select_r;
				end else if (waddr_r == `SCG_OFF_MASK) begin
					mask_r <= wstrb_r[0] ? wdata_r[1:0] : mask_r;
				end else if (waddr_r == `SCG_OFF_STAT || waddr_r == `SCG_OFF_FLT) begin
					s_axi_bresp_out <= `SCG_RESP_OKAY;
				end else begin
					s_axi_bresp_out <= `SCG_RESP_SLVERR;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	always_comb begin
		rd_val  = 32'h0000_0000;
		rd_resp = `SCG_RESP_OKAY;
		if (s_axi_araddr_in == `SCG_OFF_SLEEP) begin
			rd_val = sleep_gate_r;
		end else if (s_axi_araddr_in == `SCG_OFF_RUN) begin
			rd_val = run_gate_r;
		end else if (s_axi_araddr_in == `SCG_OFF_CTRL) begin
			rd_val[`SCG_BIT_AUTO] = auto_gate_select_r;
		end else if (s_axi_araddr_in == `SCG_OFF_STAT) begin
			rd_val[1:0] = stat_r;
		end else if (s_axi_araddr_in == `SCG_OFF_MASK) begin
			rd_val[1:0] = mask_r;
		end else if (s_axi_araddr_in == `SCG_OFF_FLT) begin
			rd_val = fault_units_r;
		end else begin
			rd_resp = `SCG_RESP_SLVERR;
		end
	end

	// Read channel, one read at a time
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h0000_0000;
			s_axi_rresp_out   <= `SCG_RESP_OKAY;
		end else begin
			if (s_axi_arvalid_in && s_axi_arready_out) begin
				s_axi_arready_out <= 1'b0;
				s_axi_rvalid_out  <= 1'b1;
				s_axi_rdata_out   <= rd_val;
				s_axi_rresp_out   <= rd_resp;
			end else if (s_axi_rvalid_out && s_axi_rready_in) begin
				s_axi_rvalid_out  <= 1'b0;
			end else begin
				s_axi_arready_out <= !s_axi_rvalid_out;
			end
		end
	end

	// ----------------------------------------------------------------
	// Enable selection and bus fault check
	// ----------------------------------------------------------------
	scg_gate_mux u_gate_mux (
		.ref_clk_in    (ref_clk_in),
		.sys_rst_in    (sys_rst_in),
		.run_gate_in   (run_gate_r),
		.sleep_gate_in (sleep_gate_r),
		.src_in        (src_sel),
		.clk_en_out    (periph_clk_en_out),
		.switch_ev_out (switch_ev)
	);

	scg_fault_chk u_fault_chk (
		.ref_clk_in      (ref_clk_in),
		.sys_rst_in      (sys_rst_in),
		.preq_in         (preq_in),
		.clk_en_in       (periph_clk_en_out),
		.fault_out       (bus_fault_out),
		.fault_units_out (fault_units)
	);

	// ----------------------------------------------------------------
	// Sticky events, write-one-to-clear, set wins over clear
	// ----------------------------------------------------------------
	always_comb begin
		stat_nxt = stat_r;
		if (wr_fire && waddr_r == `SCG_OFF_STAT && wstrb_r[0]) begin
			stat_nxt = stat_nxt & ~wdata_r[1:0];
		end
		stat_nxt[`SCG_EV_FAULT]  = stat_nxt[`SCG_EV_FAULT] | bus_fault_out;
		stat_nxt[`SCG_EV_SWITCH] = stat_nxt[`SCG_EV_SWITCH] | switch_ev;
	end

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			stat_r        <= `SCG_EV_RST;
			fault_units_r <= 32'h0000_0000;
			irq_out       <= 1'b0;
		end else begin
			stat_r        <= stat_nxt;
			fault_units_r <= bus_fault_out ? fault_units : fault_units_r;
			irq_out       <= |(stat_nxt & mask_r);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);

	sequence wr_sleep_s;
		wr_fire && waddr_r == `SCG_OFF_SLEEP;
	endsequence

	sequence rd_sleep_s;
		s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == `SCG_OFF_SLEEP;
	endsequence

	en_follow_src_a: assert property (
		##1 periph_clk_en_out == ($past(src_sel) == scg_pkg::SCG_SRC_SLEEP ? $past(sleep_gate_r)
			: $past(run_gate_r))) else $error("clock enables do not follow selected gate register");
	sleep_needs_auto_a: assert property (
		!(cpu_sleep_in && auto_gate_select_r) |=> periph_clk_en_out == $past(run_gate_r))
		else $error("sleep gating used without auto gate select");
	fault_gated_a: assert property (
		preq_in.valid && (preq_in.unit_sel & ~periph_clk_en_out) != 32'h0000_0000 |=> bus_fault_out ##1 stat_r[0])
		else $error("access to unclocked unit gave no fault");
	no_fault_clocked_a: assert property (
		!(preq_in.valid && (preq_in.unit_sel & ~periph_clk_en_out) != 32'h0000_0000) |=> !bus_fault_out)
		else $error("fault raised for clocked unit");
	reset_zero_a: assert property (
		$past(sys_rst_in) |-> sleep_gate_r == 32'h0000_0000 && periph_clk_en_out == 32'h0000_0000)
		else $error("gate bits not zero after reset");
	reserved_zero_a: assert property (
		(sleep_gate_r & ~gate_wmask) == 32'h0000_0000 && (run_gate_r & ~gate_wmask) == 32'h0000_0000)
		else $error("reserved gate bit set");
	sleep_write_a: assert property (
		wr_sleep_s |=> sleep_gate_r == ($past(lane_merge(sleep_gate_r, wdata_r, wstrb_r)) & gate_wmask)
			&& s_axi_bvalid_out && s_axi_bresp_out == `SCG_RESP_OKAY)
		else $error("sleep gate write lost or misplaced");
	sleep_read_a: assert property (
		rd_sleep_s |=> s_axi_rvalid_out && s_axi_rdata_out == $past(sleep_gate_r)
			&& s_axi_rresp_out == `SCG_RESP_OKAY) else $error("sleep gate read wrong");
	irq_level_a: assert property (
		##1 irq_out == |(stat_r & $past(mask_r))) else $error("interrupt level wrong");

endmodule // scg_top

/* scg_periph_model.sv */
// Peripheral side model: offers unit accesses and watches the clock enables it is given.
// Assumes the bench asks for accesses on the gate block's clock.
`timescale 1ns/1ps

module scg_periph_model (
	input  wire logic               clk_in,
	input  wire logic               rst_in,
	input  wire scg_pkg::scg_gate_t clk_en_in,
	input  wire logic               req_in,
	input  wire logic [31:0]        sel_in,
	output scg_pkg::scg_preq_t      preq_out,
	output logic [31:0]             live_units_out
);
	// ----------------------------------------
	// Access lines
	// ----------------------------------------
	logic [31:0] idle_r;

	// Select lines change every idle cycle so a stale value never looks valid
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			idle_r <= 32'h5a5a_a5a5;
		end else begin
			idle_r <= ~preq_out.unit_sel;
		end
	end

	// Any unit may be addressed, clocked or not
	assign preq_out.valid    = req_in;
	assign preq_out.unit_sel = req_in ? sel_in : idle_r;
	// A unit works only while its enable is high
	assign live_units_out    = clk_en_in;
endmodule // scg_periph_model

/* tb.sv */
// Self-checking bench of the sleep clock gate block: registers, source selection, faults, interrupt.
// Assumes scg_cfg.svh, scg_pkg and the design files are compiled first; one 40 MHz clock.
`timescale 1ns/1ps
`include "scg_cfg.svh"

module tb;
	// ----------------------------------------
	// Signals and model state
	// ----------------------------------------
	localparam logic [31:0] GATE_MASK = 32'h0707_1011;
	logic               ref_clk, sys_rst, cpu_sleep, req;
	logic               awvalid, wvalid, bready, arvalid, rready;
	logic               awready, wready, bvalid, arready, rvalid, fault, irq;
	logic [11:0]        awaddr, araddr;
	logic [31:0]        wdata, rdata, sel, live, got, d;
	logic [3:0]         wstrb, s;
	logic [1:0]         bresp, rresp, resp;
	scg_pkg::scg_preq_t preq;
	scg_pkg::scg_gate_t clk_en;
	int                 bad_count, checks_done, run_m, sleep_m, ctrl_m, en_m, stat_m;
	int                 ub[9] = '{26, 25, 24, 18, 17, 16, 12, 4, 0};
	logic [11:0]        offs[6] = '{`SCG_OFF_RUN, `SCG_OFF_SLEEP, `SCG_OFF_CTRL,
		`SCG_OFF_STAT, `SCG_OFF_MASK, `SCG_OFF_FLT};

	scg_top scg_top_inst (.ref_clk_in(ref_clk), .sys_rst_in(sys_rst),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
		.s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .cpu_sleep_in(cpu_sleep),
		.preq_in(preq), .periph_clk_en_out(clk_en), .bus_fault_out(fault), .irq_out(irq));

	scg_periph_model scg_periph_model_inst (.clk_in(ref_clk), .rst_in(sys_rst),
		.clk_en_in(clk_en), .req_in(req), .sel_in(sel), .preq_out(preq), .live_units_out(live));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Compare one value and count it
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	// AXI4-Lite write; each channel released at its own handshake
	task automatic axw(input logic [11:0] a, input logic [31:0] v, input logic [3:0] st);
		int n;
		n = 0;
		@(posedge ref_clk);
		awaddr  <= a;
		wdata   <= v;
		wstrb   <= st;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 50);
		resp = bresp;
		bready <= 1'b0;
		if (n >= 50) begin
			bad_count++;
			$display("mismatch %0t write response timed out", $time);
		end
	endtask

	// AXI4-Lite read
	task automatic axr(input logic [11:0] a);
		int n;
		n = 0;
		@(posedge ref_clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 50);
		got = rdata;
		resp = rresp;
		rready <= 1'b0;
		if (n >= 50) begin
			bad_count++;
			$display("mismatch %0t read data timed out", $time);
		end
	endtask

	// Byte-lane merge, then only gate bits survive
	function automatic int merge(int old, logic [31:0] v, logic [3:0] st);
		int r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (st[b]) r[8*b +: 8] = v[8*b +: 8];
		return r & GATE_MASK;
	endfunction

	// One access to unit u; fault expected when its enable is low
	task automatic poke(input int u);
		@(posedge ref_clk);
		req <= 1'b1;
		sel <= 32'h1 << u;
		@(posedge ref_clk);
		req <= 1'b0;
		@(posedge ref_clk);
		chk(fault, {31'h0, ~en_m[u]}, "bus fault");
		if (en_m[u] == 0) stat_m |= 1;
	endtask

	task end_of_test();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Clock, watchdog, sequence
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// Whole run needs a few hundred cycles
	initial begin
		#500000;
		bad_count++;
		$display("mismatch %0t watchdog expired", $time);
		end_of_test();
	end

	initial begin
		{sys_rst, cpu_sleep, req, awvalid, wvalid, bready, arvalid, rready} = 8'h80;
		{awaddr, araddr, wdata, wstrb, sel} = '0;
		void'($urandom(32'h72a7));
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk(live, 32'h0, "enables after reset");
		foreach (offs[i]) begin
			axr(offs[i]);
			chk(got, 32'h0, "reset value");
		end
		// Reserved bits stay zero, each gate bit writable alone
		axw(`SCG_OFF_SLEEP, 32'hffff_ffff, 4'hf);
		axr(`SCG_OFF_SLEEP);
		chk(got, GATE_MASK, "writable bits");
		foreach (ub[i]) begin
			axw(`SCG_OFF_SLEEP, 32'h1 << ub[i], 4'hf);
			axr(`SCG_OFF_SLEEP);
			chk(got, 32'h1 << ub[i], "single gate bit");
		end
		sleep_m = 32'h1;
		// Random values and strobes into both gate registers
		for (int k = 0; k < 8; k++) begin
			d = $urandom;
			s = 4'($urandom);
			axw(k[0] ? `SCG_OFF_SLEEP : `SCG_OFF_RUN, d, s);
			chk(resp, `SCG_RESP_OKAY, "write resp");
			if (k[0]) sleep_m = merge(sleep_m, d, s);
			else run_m = merge(run_m, d, s);
			axr(k[0] ? `SCG_OFF_SLEEP : `SCG_OFF_RUN);
			chk(got, k[0] ? sleep_m : run_m, "gate readback");
		end
		axw(12'h200, 32'hffff_ffff, 4'hf);
		chk(resp, `SCG_RESP_SLVERR, "unmapped write");
		axr(12'h200);
		chk(got, 32'h0, "unmapped read data");
		chk(resp, `SCG_RESP_SLVERR, "unmapped read resp");
		axw(`SCG_OFF_MASK, 32'h1, 4'hf);
		// Every mode: enables follow the chosen register, faults follow enables
		for (int m = 0; m < 4; m++) begin
			cpu_sleep <= m[0];
			axw(`SCG_OFF_CTRL, m[1], 4'hf);
			ctrl_m = m[1];
			repeat (3) @(posedge ref_clk);
			en_m = (m[0] && ctrl_m[0]) ? sleep_m : run_m;
			chk(live, en_m, "clock enables");
			foreach (ub[i]) poke(ub[i]);
			poke(31);
		end
		// Only the last mode moved the enables onto the sleep bits
		stat_m |= 2;
		repeat (2) @(posedge ref_clk);
		chk(irq, stat_m[0], "irq raised");
		axr(`SCG_OFF_STAT);
		chk(got, stat_m, "event status");
		axw(`SCG_OFF_STAT, 32'h3, 4'hf);
		repeat (3) @(posedge ref_clk);
		chk(irq, 1'b0, "irq cleared");
		axw(`SCG_OFF_MASK, 32'h0, 4'hf);
		poke(31);
		repeat (3) @(posedge ref_clk);
		chk(irq, 1'b0, "irq masked");
		axr(`SCG_OFF_STAT);
		chk(got[0], 1'b1, "masked status");
		axr(`SCG_OFF_FLT);
		chk(got, 32'h8000_0000, "fault units");
		end_of_test();
	end
endmodule // tb
